// ===== rtl/rtcp_divider.sv
// Two-stage prescaler producing one-cycle enable pulses
`timescale 1ns/100ps
module rtcp_divider (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic srcTick,
    input wire logic hold,
    input wire logic [6:0] factorA,
    input wire logic [14:0] factorS,
    output logic apreTick,
    output logic spreTick
);
    logic [6:0] cntA_reg, cntA_next;
    logic [14:0] cntS_reg, cntS_next;
    logic apre_next, spre_next;

    always_comb begin
        cntA_next = cntA_reg;
        cntS_next = cntS_reg;
        apre_next = 1'b0;
        spre_next = 1'b0;
        if (hold) begin
            // Counters clear and hold at zero in init mode so new factors start from zero
            cntA_next = 7'h00;
            cntS_next = 15'h0000;
        end else if (srcTick) begin
            if (cntA_reg >= factorA) begin // [RULE1]
                cntA_next = 7'h00;
                apre_next = 1'b1;
                if (cntS_reg >= factorS) begin // [RULE2]
                    cntS_next = 15'h0000;
                    spre_next = 1'b1;
                end else begin
                    cntS_next = cntS_reg + 15'h0001;
                end
            end else begin
                cntA_next = cntA_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cntA_reg <= 7'h00;
            cntS_reg <= 15'h0000;
            apreTick <= 1'b0;
            spreTick <= 1'b0;
        end else begin
            cntA_reg <= cntA_next;
            cntS_reg <= cntS_next;
            apreTick <= apre_next;
            spreTick <= spre_next;
        end
    end

    apre_period_a: assert property (@(posedge clk) disable iff (!rst_b)
        (srcTick && !hold && cntA_reg >= factorA) |=> apreTick) // [RULE1]
        else $error("first stage pulse missing");
    spre_only_with_apre_a: assert property (@(posedge clk) disable iff (!rst_b)
        spreTick |-> apreTick) // [RULE2]
        else $error("second stage pulse without first stage");
endmodule

// ===== rtl/rtcp_pkg.sv
// Package: register map, field layout, reset values and timing for the RTC prescaler/alarm block
// Operation
// RULE1 - First stage divides source clock by asynchronous factor plus one, bits 22:16
// RULE2 - Second stage divides first stage by synchronous factor plus one, bits 14:0
// RULE3 - Prescaler loads 0x007f00ff only on backup reset, system reset keeps it
// RULE4 - Alarm compare register clears only on backup reset, system reset keeps it
// RULE5 - Prescaler and alarm registers accept writes only in initialization state
// RULE6 - Software uses only full 32-bit word accesses to these registers
// RULE7 - Software keeps prescaler bits 31:23 and 15 at reset value
// RULE8 - Init state flag rises once init mode takes effect; gates prescaler changes
// RULE9 - Alarm write permitted flag sets once alarm enable is cleared
// RULE10 - Alarm match flag sets on calendar equal alarm; software writes zero to clear
// RULE11 - Masked alarm fields are excluded from the match comparison
package rtcp_pkg;
    localparam logic [7:0] ADDR_CTL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_PSC = 8'h10;
    localparam logic [7:0] ADDR_ALRM = 8'h1c;
    localparam logic [31:0] PSC_RESET = 32'h007f00ff;
    localparam logic [31:0] ALRM_RESET = 32'h00000000;
    localparam logic [31:0] PSC_MASK = 32'h007f7fff;
    localparam int FA_LSB = 16;
    localparam int FA_MSB = 22;
    localparam int FS_MSB = 14;
    localparam int CTL_INIT_MODE_REQUEST = 0;
    localparam int CTL_ALEN = 1;
    localparam int ST_INIT_STATE_FLAG = 0;
    localparam int ST_AWF = 1;
    localparam int ST_ALRMF = 2;
    localparam int MSK_D = 31;
    localparam int MSK_H = 23;
    localparam int MSK_M = 15;
    localparam int MSK_S = 7;
    localparam logic [1:0] INIT_SETTLE = 2'h2;
    typedef enum logic [1:0] {
        RTCP_RUN = 2'b00,
        RTCP_ENTER = 2'b01,
        RTCP_INIT = 2'b11
    } rtcp_state_t;
endpackage

// ===== rtl/rtcp_top.sv
// RTC prescaler and alarm registers with APB slave
`timescale 1ns/100ps
module rtcp_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic bkpRst_b,
    input wire logic calSrcTick,
    input wire logic [31:0] calendarNow,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic firstStageTick,
    output logic secondStageTick,
    output logic initStateFlag,
    output logic alarmMatchFlag
);
    logic src1_reg, src2_reg, src3_reg;
    logic [31:0] psc_reg, psc_next;
    logic [31:0] alrm_reg, alrm_next;
    logic initModeReq_reg, initModeReq_next;
    logic alarmEn_reg, alarmEn_next;
    logic awf_reg, awf_next;
    logic matchFlag_reg, matchFlag_next;
    logic [1:0] settle_reg, settle_next;
    rtcp_pkg::rtcp_state_t state_reg, state_next;
    logic [31:0] prdata_next;
    logic pslverr_next;
    logic access, wr, srcTick, apre, spre, fieldsMatch, initFlag;
    logic [31:0] calSync1_reg, calSync2_reg;
    logic [31:0] calSnap_reg, calSnap_next;
    logic srcFall;

    assign access = psel && penable;
    assign wr = access && pwrite;
    assign srcTick = src2_reg && !src3_reg;
    assign srcFall = src3_reg && !src2_reg;
    assign initFlag = (state_reg == rtcp_pkg::RTCP_INIT);

    // Source clock tick and calendar come from another domain
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            src1_reg <= 1'b0;
            src2_reg <= 1'b0;
            src3_reg <= 1'b0;
            calSync1_reg <= 32'h00000000;
            calSync2_reg <= 32'h00000000;
        end else begin
            src1_reg <= calSrcTick;
            src2_reg <= src1_reg;
            src3_reg <= src2_reg;
            calSync1_reg <= calendarNow;
            calSync2_reg <= calSync1_reg;
        end
    end

    // Word taken mid source period, away from its update edge; avoids a torn value
    always_comb begin
        calSnap_next = calSnap_reg;
        if (srcFall) begin
            calSnap_next = calSync2_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            calSnap_reg <= 32'h00000000;
        end else begin
            calSnap_reg <= calSnap_next;
        end
    end

    rtcp_divider u_div (
        .clk(clk),
        .rst_b(rst_b),
        .srcTick(srcTick),
        .hold(initFlag),
        .factorA(psc_reg[rtcp_pkg::FA_MSB:rtcp_pkg::FA_LSB]),
        .factorS(psc_reg[rtcp_pkg::FS_MSB:0]),
        .apreTick(apre),
        .spreTick(spre)
    );

    // Init mode entry takes a few cycles to settle before the flag rises
    always_comb begin
        state_next = state_reg;
        settle_next = settle_reg;
        case (state_reg)
            rtcp_pkg::RTCP_RUN: begin
                settle_next = 2'h0;
                if (initModeReq_reg) begin
                    state_next = rtcp_pkg::RTCP_ENTER;
                end
            end
            rtcp_pkg::RTCP_ENTER: begin
                settle_next = settle_reg + 2'h1;
                if (!initModeReq_reg) begin
                    state_next = rtcp_pkg::RTCP_RUN;
                end else if (settle_reg == rtcp_pkg::INIT_SETTLE) begin
                    state_next = rtcp_pkg::RTCP_INIT; // [RULE8]
                end
            end
            rtcp_pkg::RTCP_INIT: begin
                if (!initModeReq_reg) begin
                    state_next = rtcp_pkg::RTCP_RUN;
                end
            end
            default: begin
                state_next = rtcp_pkg::RTCP_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= rtcp_pkg::RTCP_RUN;
            settle_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            settle_reg <= settle_next;
        end
    end

    // Alarm match on unmasked fields; mask bits themselves never compared
    always_comb begin
        fieldsMatch = 1'b1;
        for (int f = 0; f < 4; f++) begin
            if (!alrm_reg[8 * f + 7]) begin // [RULE11]
                if (alrm_reg[8 * f +: 7] != calSnap_reg[8 * f +: 7]) begin
                    fieldsMatch = 1'b0;
                end
            end
        end
    end

    // Control, status and match flag
    always_comb begin
        initModeReq_next = initModeReq_reg;
        alarmEn_next = alarmEn_reg;
        matchFlag_next = matchFlag_reg;
        if (wr && paddr == rtcp_pkg::ADDR_CTL) begin
            initModeReq_next = pwdata[rtcp_pkg::CTL_INIT_MODE_REQUEST];
            alarmEn_next = pwdata[rtcp_pkg::CTL_ALEN];
        end
        if (wr && paddr == rtcp_pkg::ADDR_STAT && !pwdata[rtcp_pkg::ST_ALRMF]) begin
            matchFlag_next = 1'b0; // [RULE10]
        end
        // Set wins over a same-cycle clear
        if (alarmEn_reg && spre && fieldsMatch) begin
            matchFlag_next = 1'b1; // [RULE10]
        end
        awf_next = !alarmEn_reg; // [RULE9]
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            initModeReq_reg <= 1'b0;
            alarmEn_reg <= 1'b0;
            matchFlag_reg <= 1'b0;
            awf_reg <= 1'b1;
        end else begin
            initModeReq_reg <= initModeReq_next;
            alarmEn_reg <= alarmEn_next;
            matchFlag_reg <= matchFlag_next;
            awf_reg <= awf_next;
        end
    end

    // Backup-domain registers; system reset does not reach them
    always_comb begin
        psc_next = psc_reg;
        alrm_next = alrm_reg;
        if (wr && initFlag) begin // [RULE5]
            if (paddr == rtcp_pkg::ADDR_PSC) begin
                // Reserved bits forced so they always read at reset value
                psc_next = pwdata & rtcp_pkg::PSC_MASK;
            end else if (paddr == rtcp_pkg::ADDR_ALRM && awf_reg) begin
                alrm_next = pwdata;
            end
        end
    end

    always_ff @(posedge clk or negedge bkpRst_b) begin
        if (!bkpRst_b) begin
            psc_reg <= rtcp_pkg::PSC_RESET; // [RULE3]
            alrm_reg <= rtcp_pkg::ALRM_RESET; // [RULE4]
        end else begin
            psc_reg <= psc_next;
            alrm_reg <= alrm_next;
        end
    end

    // APB read path, zero wait states
    always_comb begin
        prdata_next = 32'h00000000;
        pslverr_next = 1'b0;
        if (psel && !penable && !pwrite) begin
            if (paddr == rtcp_pkg::ADDR_CTL) begin
                prdata_next[rtcp_pkg::CTL_INIT_MODE_REQUEST] = initModeReq_reg;
                prdata_next[rtcp_pkg::CTL_ALEN] = alarmEn_reg;
            end else if (paddr == rtcp_pkg::ADDR_STAT) begin
                prdata_next[rtcp_pkg::ST_INIT_STATE_FLAG] = initFlag;
                prdata_next[rtcp_pkg::ST_AWF] = awf_reg;
                prdata_next[rtcp_pkg::ST_ALRMF] = matchFlag_reg;
            end else if (paddr == rtcp_pkg::ADDR_PSC) begin
                prdata_next = psc_reg;
            end else if (paddr == rtcp_pkg::ADDR_ALRM) begin
                prdata_next = alrm_reg;
            end
        end
        if (psel && !penable) begin
            pslverr_next = !(paddr == rtcp_pkg::ADDR_CTL || paddr == rtcp_pkg::ADDR_STAT
                || paddr == rtcp_pkg::ADDR_PSC || paddr == rtcp_pkg::ADDR_ALRM);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b0;
            firstStageTick <= 1'b0;
            secondStageTick <= 1'b0;
            initStateFlag <= 1'b0;
            alarmMatchFlag <= 1'b0;
        end else begin
            if (psel && !penable) begin
                prdata <= prdata_next;
                pslverr <= pslverr_next;
            end
            pready <= psel && !penable;
            firstStageTick <= apre;
            secondStageTick <= spre;
            initStateFlag <= initFlag;
            alarmMatchFlag <= matchFlag_reg;
        end
    end

    psc_locked_a: assert property (@(posedge clk) disable iff (!rst_b || !bkpRst_b)
        (!initFlag) |=> (psc_reg == $past(psc_reg))) // [RULE5]
        else $error("prescaler changed outside init state");
    alrm_locked_a: assert property (@(posedge clk) disable iff (!rst_b || !bkpRst_b)
        (!initFlag) |=> (alrm_reg == $past(alrm_reg))) // [RULE5]
        else $error("alarm changed outside init state");

    // Init entry: request seen in run state, then held while the entry settles
    sequence init_req_s;
        state_reg == rtcp_pkg::RTCP_RUN && initModeReq_reg;
    endsequence
    sequence init_hold_s;
        initModeReq_reg[*3];
    endsequence

    init_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
        init_req_s ##1 init_hold_s |=> initFlag) // [RULE8]
        else $error("init state flag late");
    init_exit_a: assert property (@(posedge clk) disable iff (!rst_b)
        (initFlag && !initModeReq_reg) |=> !initFlag) // [RULE8]
        else $error("init state kept without request");
    init_needs_req_a: assert property (@(posedge clk) disable iff (!rst_b)
        initFlag |-> $past(initModeReq_reg)) // [RULE8]
        else $error("init flag without request");
    awf_follows_en_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(alarmEn_reg) |=> awf_reg) // [RULE9]
        else $error("write permitted flag not set after disable");
    match_sets_a: assert property (@(posedge clk) disable iff (!rst_b)
        (alarmEn_reg && spre && fieldsMatch) |=> matchFlag_reg ##1 alarmMatchFlag) // [RULE10]
        else $error("alarm match flag not set");
    match_cause_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(matchFlag_reg) |-> $past(alarmEn_reg && spre && fieldsMatch)) // [RULE10]
        else $error("alarm flag set without match");
    mask_all_a: assert property (@(posedge clk) disable iff (!rst_b)
        (alrm_reg[rtcp_pkg::MSK_D] && alrm_reg[rtcp_pkg::MSK_H]
        && alrm_reg[rtcp_pkg::MSK_M] && alrm_reg[rtcp_pkg::MSK_S]) |-> fieldsMatch) // [RULE11]
        else $error("fully masked alarm did not match");
    apb_ready_a: assert property (@(posedge clk) disable iff (!rst_b)
        (psel && !penable) |=> pready)
        else $error("apb ready missing");
    ready_one_cycle_a: assert property (@(posedge clk) disable iff (!rst_b)
        pready |=> !pready)
        else $error("apb ready held too long");
    unmapped_err_a: assert property (@(posedge clk) disable iff (!rst_b)
        (psel && !penable && paddr >= 8'h20) |=> pslverr)
        else $error("unmapped access without error");

    awf_clears_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(alarmEn_reg) |=> !awf_reg) // [RULE9]
        else $error("write permitted flag kept while alarm enabled");
    match_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && paddr == rtcp_pkg::ADDR_STAT && !pwdata[rtcp_pkg::ST_ALRMF] && !spre)
        |=> !matchFlag_reg) // [RULE10]
        else $error("alarm match flag not cleared");
    psc_reserved_a: assert property (@(posedge clk) disable iff (!bkpRst_b)
        (psc_reg & ~rtcp_pkg::PSC_MASK) == 32'h00000000)
        else $error("prescaler reserved bits set");
endmodule

// ===== sim/rtcp_top_tb_top.sv
// Self-checking testbench for the RTC prescaler and alarm register block
`timescale 1ns/100ps
module rtcp_top_tb_top;
    logic clk, rst_b, bkpRst_b, calSrcTick, psel, penable, pwrite;
    logic pready, pslverr, firstStageTick, secondStageTick, initStateFlag, alarmMatchFlag;
    logic [31:0] calendarNow, pwdata, prdata, rd, psc, alm;
    logic [7:0] paddr;
    logic err;
    int mismatches, check_count, seed, nA, nS, a0, s0;

    rtcp_top dut (
        .clk(clk),
        .rst_b(rst_b),
        .bkpRst_b(bkpRst_b),
        .calSrcTick(calSrcTick),
        .calendarNow(calendarNow),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .firstStageTick(firstStageTick),
        .secondStageTick(secondStageTick),
        .initStateFlag(initStateFlag),
        .alarmMatchFlag(alarmMatchFlag)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Tick pulses stand one cycle, so they are counted at every edge
    always @(posedge clk) begin
        if (firstStageTick === 1'b1) nA++;
        if (secondStageTick === 1'b1) nS++;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; read data and error taken at the edge where pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n == 50) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Pulses out of a divide-by-(f+1) stage for n pulses in, counter starting at zero
    function automatic int div_count(input int n, input int f);
        return n / (f + 1);
    endfunction

    // Source ticks are slow against clk so the synchronizer sees every edge
    task automatic src_ticks(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            calSrcTick <= 1'b1;
            repeat (4) @(posedge clk);
            calSrcTick <= 1'b0;
        end
        repeat (10) @(posedge clk);
    endtask

    task automatic enter_init();
        int n;
        n = 0;
        apb(1'b1, rtcp_pkg::ADDR_CTL, 32'h00000001);
        while (initStateFlag !== 1'b1 && n < 100) begin
            n++;
            @(posedge clk);
        end
        chk("init flag", 32'h1, initStateFlag);
    endtask

    task automatic results();
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        results();
    end

    initial begin
        seed = 32'h77a5;
        {rst_b, bkpRst_b, calSrcTick, psel, penable, pwrite} = 6'h00;
        calendarNow = 32'h00000000;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        bkpRst_b <= 1'b1;
        @(posedge clk);
        apb(1'b0, rtcp_pkg::ADDR_PSC, 32'h0);
        chk("psc reset", rtcp_pkg::PSC_RESET, rd);
        apb(1'b0, rtcp_pkg::ADDR_ALRM, 32'h0);
        chk("alarm reset", rtcp_pkg::ALRM_RESET, rd);
        // Writes outside init must bounce
        apb(1'b1, rtcp_pkg::ADDR_PSC, 32'h00010002);
        apb(1'b0, rtcp_pkg::ADDR_PSC, 32'h0);
        chk("psc locked", rtcp_pkg::PSC_RESET, rd);
        apb(1'b1, rtcp_pkg::ADDR_ALRM, 32'h12345678);
        apb(1'b0, rtcp_pkg::ADDR_ALRM, 32'h0);
        chk("alarm locked", rtcp_pkg::ALRM_RESET, rd);
        apb(1'b1, 8'h40, 32'hffffffff);
        chk("unmapped err", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        enter_init();
        apb(1'b0, rtcp_pkg::ADDR_STAT, 32'h0);
        chk("alarm write ok", 32'h1, rd[rtcp_pkg::ST_AWF]);
        // Reserved bits kept at reset value by software
        for (int i = 0; i < 6; i++) begin
            psc = (i == 0) ? rtcp_pkg::PSC_MASK : ($random(seed) & rtcp_pkg::PSC_MASK);
            alm = (i == 0) ? 32'hffffffff : $random(seed);
            apb(1'b1, rtcp_pkg::ADDR_PSC, psc);
            apb(1'b1, rtcp_pkg::ADDR_ALRM, alm);
            apb(1'b0, rtcp_pkg::ADDR_PSC, 32'h0);
            chk("psc rw", psc, rd);
            apb(1'b0, rtcp_pkg::ADDR_ALRM, 32'h0);
            chk("alarm rw", alm, rd);
        end
        // System reset alone keeps both registers
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("flag after reset", 32'h0, initStateFlag);
        apb(1'b0, rtcp_pkg::ADDR_PSC, 32'h0);
        chk("psc kept", psc, rd);
        apb(1'b0, rtcp_pkg::ADDR_ALRM, 32'h0);
        chk("alarm kept", alm, rd);
        // Divide by 2 then by 3; unmasked mismatch first
        enter_init();
        apb(1'b1, rtcp_pkg::ADDR_PSC, 32'h00010002);
        apb(1'b1, rtcp_pkg::ADDR_ALRM, 32'h01020304);
        calendarNow <= 32'h01020305;
        apb(1'b1, rtcp_pkg::ADDR_CTL, 32'h00000002);
        apb(1'b0, rtcp_pkg::ADDR_STAT, 32'h0);
        chk("alarm write barred", 32'h0, rd[rtcp_pkg::ST_AWF]);
        a0 = nA;
        s0 = nS;
        src_ticks(12);
        chk("first stage count", div_count(12, 1), nA - a0);
        chk("second stage count", div_count(div_count(12, 1), 2), nS - s0);
        chk("no match", 32'h0, alarmMatchFlag);
        calendarNow <= 32'h01020304;
        src_ticks(6);
        chk("match", 32'h1, alarmMatchFlag);
        apb(1'b1, rtcp_pkg::ADDR_STAT, 32'h0);
        repeat (3) @(posedge clk);
        chk("match cleared", 32'h0, alarmMatchFlag);
        // Every field masked: any calendar value matches
        enter_init();
        apb(1'b1, rtcp_pkg::ADDR_ALRM, $random(seed) | 32'h80808080);
        calendarNow <= $random(seed);
        apb(1'b1, rtcp_pkg::ADDR_CTL, 32'h00000002);
        src_ticks(6);
        chk("masked match", 32'h1, alarmMatchFlag);
        results();
    end
endmodule
